// [irq_prio_pkg.sv]
/*
 * Shared constants and carrier types for the four-level interrupt priority block.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses on a 25 MHz clock.
 */
package irq_prio_pkg;

    // ************************************************************
    // Sizes and register map
    // ************************************************************
    localparam int          NSRC        = 7;        // Number of request sources.
    localparam int          AW          = 10;       // Avalon byte address width.
    localparam logic [7:0]  OFS_ENABLE  = 8'hA8;    // Source enable register.
    localparam logic [7:0]  OFS_PRIO_HI = 8'hB7;    // Priority high bits (index, not aligned).
    localparam logic [7:0]  OFS_PRIO_LO = 8'hB8;    // Priority low bits (index).
    localparam logic [7:0]  OFS_STATUS  = 8'hC0;    // Sticky grant status, write one to clear.
    localparam logic [7:0]  OFS_MASK    = 8'hC1;    // Status interrupt mask.
    localparam logic [7:0]  OFS_SERVICE = 8'hC2;    // Levels in service, read only.
    localparam logic [7:0]  OFS_DONE    = 8'hC3;    // Write to end the highest service.
    localparam logic [7:0]  RST_ENABLE  = 8'h00;    // Enable reset value.
    localparam logic [6:0]  RST_PRIO    = 7'h00;    // Both priority registers reset to level 0.
    localparam logic [6:0]  RST_MASK    = 7'h00;    // Mask reset value.
    localparam int          GLOBAL_BIT  = 7;        // Global enable bit position.

    // ************************************************************
    // Source positions, shared by enable and priority registers
    // ************************************************************
    localparam int SRC_EXT0  = 0;
    localparam int SRC_TMR0  = 1;
    localparam int SRC_EXT1  = 2;
    localparam int SRC_TMR1  = 3;
    localparam int SRC_SER   = 4;
    localparam int SRC_TMR2  = 5;
    localparam int SRC_ARRAY = 6;

    // ************************************************************
    // Vector addresses
    // ************************************************************
    localparam logic [7:0] VEC_EXT0  = 8'h03;
    localparam logic [7:0] VEC_TMR0  = 8'h0B;
    localparam logic [7:0] VEC_EXT1  = 8'h13;
    localparam logic [7:0] VEC_TMR1  = 8'h1B;
    localparam logic [7:0] VEC_SER   = 8'h23;
    localparam logic [7:0] VEC_TMR2  = 8'h2B;
    localparam logic [7:0] VEC_ARRAY = 8'h33;

    // Grant carried to the core: vector, level and the source bit.
    typedef struct packed {
        logic            valid;
        logic [7:0]      vector;
        logic [1:0]      level;
        logic [NSRC-1:0] source;
    } grant_t;

endpackage : irq_prio_pkg

// [irq_level_stack.sv]
/*
 * Tracks which of the four priority levels are in service.
 * Assumes grant and done pulses come from the same clock domain.
 */
`timescale 1ns/1ps
module irq_level_stack
    import irq_prio_pkg::*;
(
    // Clock and reset.
    input  wire logic       mclk,
    input  wire logic       rstn,
    // Service events.
    input  wire logic       push,
    input  wire logic [1:0] push_level,
    input  wire logic       pop,
    // State.
    output logic [3:0]      active,
    output logic [2:0]      floor
);

    // ************************************************************
    // Active level bits
    // ************************************************************
    // A pop retires the highest active level, which is always the one
    // running since lower levels only resume after it ends.
    logic [3:0] top_bit;                            // One-hot highest active level.
    assign top_bit = active[3] ? 4'h8 : active[2] ? 4'h4 :
                     active[1] ? 4'h2 : active[0] ? 4'h1 : 4'h0;

    // Floor is one above the highest level in service; 0 when idle.
    assign floor = active[3] ? 3'h4 : active[2] ? 3'h3 :
                   active[1] ? 3'h2 : active[0] ? 3'h1 : 3'h0;

    // Active bits update on every edge.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            active <= 4'h0;
        end else begin
            active <= (active & ~(pop ? top_bit : 4'h0)) |
                      (push ? (4'h1 << push_level) : 4'h0);
        end
    end

endmodule : irq_level_stack

// [irq_prio_ctrl.sv]
/*
 * Four-level nested interrupt controller with Avalon-MM register access.
 * Assumes request flags come from same-clock peripheral logic, and the
 * core takes a grant the cycle it is shown and reports each routine end.
 */
// Added by the designer: register access over Avalon-MM.
// How it works
// - Level is high bit then low bit.
// - Grant only above every level in service.
// - Equal or lower request waits, retried later.
// - Higher level preempts; nesting reaches four levels.
// - Same level resolved by fixed polling order.
// - Fixed vector address for each source.
// - Clear edge externals and timer 0/1 flags.
// - Seven sources, four levels, two priority registers.
// - Enable register layout, global bit masks all.
// - High priority register at B7H, read/write.
// - High priority bit 7 unused, reads zero.
`timescale 1ns/1ps
module irq_prio_ctrl
    import irq_prio_pkg::*;
(
    // Clock and reset.
    input  wire logic            mclk,
    input  wire logic            rstn,
    // Avalon-MM slave.
    input  wire logic [AW-1:0]   avs_address,
    input  wire logic            avs_read,
    input  wire logic            avs_write,
    input  wire logic [31:0]     avs_writedata,
    input  wire logic [3:0]      avs_byteenable,
    output logic [31:0]          avs_readdata,
    output logic                 avs_waitrequest,
    // Request flags.
    input  wire logic            ext0_request_flag,
    input  wire logic            ext0_edge_mode,
    input  wire logic            timer0_overflow_flag,
    input  wire logic            ext1_request_flag,
    input  wire logic            ext1_edge_mode,
    input  wire logic            timer1_overflow_flag,
    input  wire logic            counter_array_overflow_flag,
    input  wire logic [4:0]      module_event_flag,
    input  wire logic            serial_receive_flag,
    input  wire logic            serial_transmit_flag,
    input  wire logic            timer2_overflow_flag,
    input  wire logic            timer2_external_flag,
    // Core side.
    input  wire logic            take,
    input  wire logic            service_done,
    output grant_t               grant,
    output logic [NSRC-1:0]      flag_clear,
    output logic                 irq
);

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0]      source_enable_reg;             // Enables plus global bit.
    logic [6:0]      priority_high_reg;             // High priority bits.
    logic [6:0]      priority_low_reg;              // Low priority bits.
    logic [6:0]      status;                        // Sticky grant events.
    logic [6:0]      mask;                          // Status mask.
    logic            ack;                           // Bus answer phase.
    logic [3:0]      active;                        // Levels in service.
    logic [2:0]      floor;                         // Lowest grantable level, one above the highest in service.

    // ************************************************************
    // Bus decode
    // ************************************************************
    // One wait cycle on every access keeps read data registered.
    wire             req     = avs_read | avs_write;
    wire             wr_go   = avs_write && ack;
    wire             lane0   = avs_byteenable[0];
    // Registers sit one to a 32-bit word, so the two low address bits
    // only pick a byte lane and take no part in the decode.
    wire [7:0]       idx     = avs_address[AW-1:2]; // Word index.
    wire             sel_en  = idx == OFS_ENABLE;
    wire             sel_hi  = idx == OFS_PRIO_HI;
    wire             sel_lo  = idx == OFS_PRIO_LO;
    wire             sel_st  = idx == OFS_STATUS;
    wire             sel_mk  = idx == OFS_MASK;
    wire             sel_sv  = idx == OFS_SERVICE;
    wire             sel_dn  = idx == OFS_DONE;
    wire             done_wr = wr_go && lane0 && sel_dn;

    // Unmapped addresses read zero and ignore writes.
    wire [7:0] rd_byte = sel_en ? source_enable_reg :
                         sel_hi ? {1'b0, priority_high_reg} :
                         sel_lo ? {1'b0, priority_low_reg} :
                         sel_st ? {1'b0, status} :
                         sel_mk ? {1'b0, mask} :
                         sel_sv ? {4'h0, active} : 8'h00;

    assign avs_waitrequest = req && !ack;

    // Answer flop toggles the wait phase off for one cycle.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ack          <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack          <= req && !ack;
            avs_readdata <= {24'h00_0000, rd_byte};
        end
    end

    // Register writes, low byte lane only.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            source_enable_reg <= RST_ENABLE;
            priority_high_reg <= RST_PRIO;
            priority_low_reg  <= RST_PRIO;
            mask              <= RST_MASK;
        end else if (wr_go && lane0) begin
            if (sel_en) source_enable_reg <= avs_writedata[7:0];
            if (sel_hi) priority_high_reg <= avs_writedata[6:0];
            if (sel_lo) priority_low_reg  <= avs_writedata[6:0];
            if (sel_mk) mask              <= avs_writedata[6:0];
        end
    end

    // ************************************************************
    // Request gathering and arbitration
    // ************************************************************
    // Request vector in register bit order. Array, serial and timer 2
    // stay set after vectoring; their routines must clear them.
    wire [NSRC-1:0] raw;
    assign raw[SRC_EXT0]  = ext0_request_flag;
    assign raw[SRC_TMR0]  = timer0_overflow_flag;
    assign raw[SRC_EXT1]  = ext1_request_flag;
    assign raw[SRC_TMR1]  = timer1_overflow_flag;
    assign raw[SRC_ARRAY] = counter_array_overflow_flag | (|module_event_flag);
    assign raw[SRC_SER]   = serial_receive_flag | serial_transmit_flag;
    assign raw[SRC_TMR2]  = timer2_overflow_flag | timer2_external_flag;

    // Global enable masks everything.
    wire [NSRC-1:0] pend = raw & source_enable_reg[NSRC-1:0] &
                           {NSRC{source_enable_reg[GLOBAL_BIT]}};

    // Per-source level: high bit over low bit.
    logic [1:0] lvl [NSRC];
    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : g_lvl
            assign lvl[g] = {priority_high_reg[g], priority_low_reg[g]};
        end
    endgenerate

    // Polling order, first wins among equal levels.
    localparam int ORD [NSRC] = '{SRC_EXT0, SRC_TMR0, SRC_EXT1, SRC_TMR1,
                                  SRC_ARRAY, SRC_SER, SRC_TMR2};

    // Pick highest level, then first in polling order.
    logic [2:0] win_idx;
    logic [1:0] win_lvl;
    logic       win_any;
    always_comb begin
        win_idx = 3'd0;
        win_lvl = 2'd0;
        win_any = 1'b0;
        for (int i = 0; i < NSRC; i++) begin
            if (pend[ORD[i]] && (!win_any || lvl[ORD[i]] > win_lvl)) begin
                win_any = 1'b1;
                win_idx = 3'(ORD[i]);
                win_lvl = lvl[ORD[i]];
            end
        end
    end

    // Only a level above all in service may be offered; others wait.
    wire can_grant = win_any && ({1'b0, win_lvl} >= floor);

    // Vector lookup.
    wire [7:0] vec = (win_idx == 3'(SRC_EXT0)) ? VEC_EXT0 :
                     (win_idx == 3'(SRC_TMR0)) ? VEC_TMR0 :
                     (win_idx == 3'(SRC_EXT1)) ? VEC_EXT1 :
                     (win_idx == 3'(SRC_TMR1)) ? VEC_TMR1 :
                     (win_idx == 3'(SRC_SER))  ? VEC_SER  :
                     (win_idx == 3'(SRC_TMR2)) ? VEC_TMR2 : VEC_ARRAY;

    wire [NSRC-1:0] win_bit = NSRC'(1) << win_idx;
    wire            taken   = grant.valid && take;
    wire            pop     = service_done | done_wr;

    // Flags that hardware clears on vectoring.
    wire [NSRC-1:0] hw_clr;
    assign hw_clr[SRC_EXT0]  = ext0_edge_mode;
    assign hw_clr[SRC_TMR0]  = 1'b1;
    assign hw_clr[SRC_EXT1]  = ext1_edge_mode;
    assign hw_clr[SRC_TMR1]  = 1'b1;
    assign hw_clr[SRC_SER]   = 1'b0;
    assign hw_clr[SRC_TMR2]  = 1'b0;
    assign hw_clr[SRC_ARRAY] = 1'b0;

    // Grant register; it drops the cycle after it is taken so that the
    // stack update is seen before the next offer.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            grant      <= '0;
            flag_clear <= '0;
        end else begin
            grant.valid  <= can_grant && !taken && !pop;
            grant.vector <= vec;
            grant.level  <= win_lvl;
            grant.source <= win_bit;
            flag_clear   <= taken ? (grant.source & hw_clr) : '0;
        end
    end

    // ************************************************************
    // Service tracking and status interrupt
    // ************************************************************
    irq_level_stack irq_level_stack_inst (
        .mclk       (mclk),
        .rstn       (rstn),
        .push       (taken),
        .push_level (grant.level),
        .pop        (pop),
        .active     (active),
        .floor      (floor)
    );

    // Set wins over a write-one clear in the same cycle.
    wire [6:0] st_clr = (wr_go && lane0 && sel_st) ? avs_writedata[6:0] : 7'h00;
    wire [6:0] st_set = taken ? grant.source : 7'h00;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            status <= 7'h00;
        end else begin
            status <= (status & ~st_clr) | st_set;
        end
    end

    assign irq = |(status & mask);

    // ************************************************************
    // Checks
    // ************************************************************
    // Every check runs on the core clock and rests while reset is held.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    // A grant that the core accepts.
    sequence s_take;
        grant.valid && take;
    endsequence

    // Global enable seen low on two edges in a row.
    sequence s_global_off;
        !source_enable_reg[GLOBAL_BIT] ##1 !source_enable_reg[GLOBAL_BIT];
    endsequence

    // An offer lies above every level that was in service.
    grant_above_a: assert property (grant.valid |-> {1'b0, grant.level} >= $past(floor))
        else $error("grant not above level in service");

    // A taken level is in service next, unless an end came with it.
    nest_push_a: assert property (s_take ##1 !$past(pop) |-> active[$past(grant.level)])
        else $error("taken level not marked in service");

    // Nothing is offered while the global enable stays off.
    no_global_a: assert property (s_global_off |-> !grant.valid)
        else $error("grant while global enable off");

    // The serial source is never offered while its enable was off.
    src_off_a: assert property (grant.valid && grant.source[SRC_SER] |->
                                $past(source_enable_reg[SRC_SER]))
        else $error("disabled source offered");

    // The serial source carries its fixed vector.
    vec_map_a: assert property (grant.valid && grant.source[SRC_SER] |-> grant.vector == VEC_SER)
        else $error("serial vector wrong");

    // At one level external 0 is polled ahead of timer 0.
    poll_first_a: assert property (grant.valid && grant.source[SRC_TMR0] |->
                                   !$past(pend[SRC_EXT0] && lvl[SRC_EXT0] == lvl[SRC_TMR0]))
        else $error("polling order broken");

    // Timer 0 loses its flag on vectoring.
    clr_t0_a: assert property (s_take ##0 grant.source[SRC_TMR0] |=> flag_clear[SRC_TMR0])
        else $error("timer 0 flag not cleared");

    // External 0 loses its flag only when it is edge triggered.
    clr_ext_a: assert property (s_take ##0 grant.source[SRC_EXT0] |=>
                                flag_clear[SRC_EXT0] == $past(ext0_edge_mode))
        else $error("external 0 clear does not follow its mode");

    // The serial and timer 2 flags, software owned, never see a hardware clear.
    no_clr_ser_a: assert property (flag_clear[SRC_SER] == 1'b0 && flag_clear[SRC_TMR2] == 1'b0)
        else $error("software owned flag cleared");

    // The unused high priority bit reads as zero.
    hi_bit7_a: assert property (ack && sel_hi |=> avs_readdata[7] == 1'b0)
        else $error("high priority bit 7 not zero");

    // Nothing is offered while level 3, the top level, is in service.
    wait_equal_a: assert property (active[3] |-> !grant.valid || $past(!active[3]))
        else $error("grant while top level in service");

    // The offered level is the source's two priority bits.
    level_map_a: assert property (grant.valid |-> grant.level ==
                                  $past({priority_high_reg[win_idx], priority_low_reg[win_idx]}))
        else $error("level does not match priority bits");

endmodule : irq_prio_ctrl

// [core_model.sv]
/*
 * Behavioural processor core that accepts vector grants and nests routines.
 * Assumes the controller's grant is registered on mclk and that the bench
 * says when a routine ends and when acceptance is to be held off.
 */
`timescale 1ns/1ps
module core_model
    import irq_prio_pkg::*;
(
    // Clock and reset.
    input  wire logic   mclk,
    input  wire logic   rstn,
    // Grant from the controller.
    input  wire grant_t grant,
    // Bench controls: hold off acceptance, end the current routine.
    input  wire logic   stall,
    input  wire logic   finish,
    // Answers to the controller.
    output logic        take,
    output logic        service_done,
    output logic [2:0]  depth
);
    // ************************************************************
    // Acceptance and nesting
    // ************************************************************
    // A stalled core leaves the grant standing, as a slow core would.
    assign take         = grant.valid & ~stall;
    // A routine can only end if one is running.
    assign service_done = finish & (depth != 3'h0);

    // Each accepted grant nests one routine; each end resumes the one below.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            depth <= 3'h0;
        end else begin
            depth <= depth + 3'(take) - 3'(service_done);
        end
    end
endmodule : core_model

// [four_level_interrupt_priority_bench.sv]
/*
 * Self-checking bench for the four-level interrupt priority controller.
 * Assumes the controller package and the core model; the bench plays the
 * peripherals that raise flags and the software that programs registers.
 */
`timescale 1ns/1ps
module four_level_interrupt_priority_bench
    import irq_prio_pkg::*;
;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    localparam logic [7:0] VTAB [7] = '{VEC_EXT0, VEC_TMR0, VEC_EXT1, VEC_TMR1, VEC_SER, VEC_TMR2, VEC_ARRAY};
    logic          mclk    = 1'b0;   // System clock.
    logic          rstn    = 1'b0;   // Reset, active low.
    logic [AW-1:0] addr    = '0;     // Bus address.
    logic          rd      = 1'b0;   // Bus read request.
    logic          wr      = 1'b0;   // Bus write request.
    logic [31:0]   wdata   = '0;     // Bus write data.
    logic [31:0]   rdata;            // Bus read data.
    logic          wreq;             // Bus wait request.
    logic [6:0]    f       = '0;     // Request flags in enable-bit order.
    logic [3:0]    modes   = '0;     // Edge modes and flag selectors.
    logic [2:0]    arr_sel = '0;     // Which counter array flag is raised.
    logic          stall   = 1'b0;   // Core holds off acceptance.
    logic          finish  = 1'b0;   // Core ends its routine.
    logic          take;
    logic          sdone;
    logic          irq;
    logic [2:0]    depth;
    logic [6:0]    fclr;
    grant_t        grant;
    logic [6:0]    hi      = '0;     // Expected high priority bits.
    logic [6:0]    lo      = '0;     // Expected low priority bits.
    logic [3:0]    act     = '0;     // Levels in service, as the bench expects.
    logic [7:0]    q;                // Last read value.
    int            miscompares = 0;
    int            checks_done = 0;

    irq_prio_ctrl irq_prio_ctrl_inst (.mclk(mclk), .rstn(rstn), .avs_address(addr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hF), .avs_readdata(rdata),
        .avs_waitrequest(wreq), .ext0_request_flag(f[0]), .ext0_edge_mode(modes[0]),
        .timer0_overflow_flag(f[1]), .ext1_request_flag(f[2]), .ext1_edge_mode(modes[1]),
        .timer1_overflow_flag(f[3]), .counter_array_overflow_flag(f[6] & (arr_sel > 3'h4)),
        .module_event_flag((f[6] && arr_sel < 3'h5) ? 5'h01 << arr_sel : 5'h00),
        .serial_receive_flag(f[4] & ~modes[2]), .serial_transmit_flag(f[4] & modes[2]),
        .timer2_overflow_flag(f[5] & ~modes[3]), .timer2_external_flag(f[5] & modes[3]),
        .take(take), .service_done(sdone), .grant(grant), .flag_clear(fclr), .irq(irq));
    core_model core_model_inst (.mclk(mclk), .rstn(rstn), .grant(grant), .stall(stall), .finish(finish),
        .take(take), .service_done(sdone), .depth(depth));

    // Clock; peripherals drop flags that the controller clears for them.
    initial forever #20 mclk = ~mclk;
    // Only a real clear writes, so a new flag set at the same edge survives.
    always @(posedge mclk) if (fclr != 7'h00) f <= f & ~fclr;
    // Watchdog: the tests need a few thousand cycles at most.
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        close_out();
    end

    // ************************************************************
    // Tasks and expectation functions
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out

    // One bus cycle; entered just after an edge, held until waitrequest is low.
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        addr <= {a, 2'b00};
        wdata <= {24'h000000, d};
        rd <= ~w;
        wr <= w;
        do @(posedge mclk); while (wreq !== 1'b0);
        q = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge mclk);
    endtask : bus

    // Best grantable source: highest level above service, then polling order.
    function automatic int pick(input logic [6:0] r, input logic [6:0] h, input logic [6:0] l);
        int ord [7] = '{0, 1, 2, 3, 6, 4, 5};
        for (int lv = 3; lv >= 0; lv--)
            for (int k = 0; k < 7; k++)
                if (r[ord[k]] && int'({h[ord[k]], l[ord[k]]}) == lv && (act >> lv) == 0) return ord[k];
        return 0;
    endfunction : pick

    // Waits for source i to be granted and accepted, then checks the aftermath.
    task automatic wait_grant(input int i);
        int n;
        logic [6:0] ec;
        n = 0;
        ec = (i == 1 || i == 3 || (i == 0 && modes[0]) || (i == 2 && modes[1])) ? 7'h01 << i : 7'h00;
        do @(negedge mclk); while ((grant.valid & take) !== 1'b1 && n++ < 12);
        check(grant.valid & take, 1'b1, "grant taken");
        check(grant.vector, VTAB[i], "vector");
        check(grant.level, {hi[i], lo[i]}, "level");
        check(grant.source, 7'h01 << i, "source");
        @(negedge mclk);
        check(fclr, ec, "hardware flag clear");
        act[{hi[i], lo[i]}] = 1'b1;
        repeat (2) @(posedge mclk);
    endtask : wait_grant

    task automatic expect_none(input int n);
        repeat (n) begin
            @(negedge mclk);
            check(grant.valid, 1'b0, "unexpected grant");
        end
        @(posedge mclk);
    endtask : expect_none

    // Ends the innermost routine; the expected in-service set drops its top level.
    task automatic end_routine();
        finish <= 1'b1;
        @(posedge mclk);
        finish <= 1'b0;
        for (int l = 3; l >= 0; l--) if (act[l]) begin
            act[l] = 1'b0;
            break;
        end
        @(posedge mclk);
    endtask : end_routine

    task automatic irq_is(input logic e);
        @(negedge mclk);
        check(irq, e, "irq level");
        @(posedge mclk);
    endtask : irq_is

    initial begin
        logic [6:0] r;
        void'($urandom(19718));
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        // Reset values, unused bit 7 and an unmapped address.
        foreach (VTAB[k]) if (k < 6) begin
            bus(1'b0, k == 0 ? OFS_ENABLE : k == 1 ? OFS_PRIO_HI : k == 2 ? OFS_PRIO_LO :
                k == 3 ? OFS_MASK : k == 4 ? OFS_STATUS : OFS_SERVICE, 8'h00);
            check(q, 8'h00, "reset value");
        end
        bus(1'b1, OFS_PRIO_HI, 8'hFF);
        bus(1'b0, OFS_PRIO_HI, 8'h00);
        check(q, 8'h7F, "high priority bits");
        bus(1'b1, OFS_PRIO_LO, 8'hFF);
        bus(1'b0, OFS_PRIO_LO, 8'h00);
        check(q, 8'h7F, "low priority bits");
        r = 7'($urandom);
        bus(1'b1, OFS_ENABLE, {1'b1, r});
        bus(1'b0, OFS_ENABLE, 8'h00);
        check(q, {1'b1, r}, "enable readback");
        bus(1'b1, 8'h10, 8'h5A);
        bus(1'b0, 8'h10, 8'h00);
        check(q, 8'h00, "unmapped read");
        $display("test registers done");
        // Random priorities and flag sets, sometimes with a slow core.
        for (int it = 0; it < 24; it++) begin
            hi = 7'($urandom);
            lo = 7'($urandom);
            modes <= 4'($urandom);
            arr_sel <= 3'($urandom_range(5));
            bus(1'b1, OFS_PRIO_HI, {1'b0, hi});
            bus(1'b1, OFS_PRIO_LO, {1'b0, lo});
            bus(1'b1, OFS_ENABLE, 8'hFF);
            r = (it == 0) ? 7'h7F : 7'($urandom_range(127, 1));
            f <= r;
            if (it % 2 == 1) begin
                stall <= 1'b1;
                repeat (3) @(posedge mclk);
                @(negedge mclk);
                check(grant.valid, 1'b1, "grant stands");
                @(posedge mclk);
                stall <= 1'b0;
            end
            wait_grant(pick(r, hi, lo));
            f <= 7'h00;
            end_routine();
        end
        $display("test random arbitration done");
        // Four-deep nesting, waiting and resumption.
        modes <= 4'h3;
        hi = 7'h05;
        lo = 7'h0C;
        bus(1'b1, OFS_PRIO_HI, {1'b0, hi});
        bus(1'b1, OFS_PRIO_LO, {1'b0, lo});
        f <= 7'h10;
        wait_grant(4);
        f <= f | 7'h20;
        expect_none(4);
        f <= f | 7'h08;
        wait_grant(3);
        f <= f | 7'h01;
        wait_grant(0);
        f <= f | 7'h04;
        wait_grant(2);
        bus(1'b0, OFS_SERVICE, 8'h00);
        check(q, 8'h0F, "four levels in service");
        repeat (3) end_routine();
        expect_none(3);
        f <= f & 7'h6F;
        end_routine();
        wait_grant(5);
        f <= 7'h00;
        end_routine();
        $display("test nesting done");
        // Global and per-source enables, then the status interrupt.
        hi = 7'h00;
        lo = 7'h00;
        bus(1'b1, OFS_PRIO_HI, 8'h00);
        bus(1'b1, OFS_PRIO_LO, 8'h00);
        bus(1'b1, OFS_STATUS, 8'h7F);
        bus(1'b1, OFS_ENABLE, 8'h7F);
        f <= 7'h01;
        expect_none(5);
        bus(1'b1, OFS_ENABLE, 8'h80);
        expect_none(3);
        bus(1'b1, OFS_ENABLE, 8'h81);
        wait_grant(0);
        bus(1'b0, OFS_STATUS, 8'h00);
        check(q, 8'h01, "status sticky bit");
        irq_is(1'b0);
        bus(1'b1, OFS_MASK, 8'h01);
        irq_is(1'b1);
        bus(1'b1, OFS_STATUS, 8'h01);
        irq_is(1'b0);
        f <= 7'h00;
        end_routine();
        $display("test enables and status done");
        close_out();
    end
endmodule : four_level_interrupt_priority_bench
